/* cevr_unit.sv */
// cpu exception control: status bits, vector choice, priority, reset entry
// assumes pipeline supplies one cycle exception requests and the serial
// boot mode bits are already assembled by the reset sequencer outside.
//
// Contract
// - taking exception sets exception level bit
// - exception return clears exception level bit
// - cold, soft reset, nmi use reset vector
// - boot bit clear selects cached normal vectors
// - boot bit set selects uncached boot vectors
// - cache error vector always uncached
// - refill vector chosen by missing address space; here 64-bit refill shares the refill entry
// - supervisor mapped region uses kernel extended bit
// - every tlb exception loads faulting page pair
// - report only highest priority exception
// - fixed priority order, cold reset highest
// - grant with reset means cold, else soft
// - soft reset can never be masked
// - cold reset fetch at short/extended reset vector
// - cold reset clears soft/tlb flags, sets error/boot
// - cold reset inits random, wired, hold, filters
// - cold reset loads config, saves pc
// - cold reset drops pending errors, watches, irqs
// - soft reset alters only listed state
// - soft reset accepted any cycle, aborts ops
// - soft reset and nmi leave identical state
// - asserted active low nmi input raises nmi
// - miss with level bit set uses general
`timescale 1ns/10ps

module cevr_unit import cevr_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // external system pins
  input wire logic system_reset_n_i,
  input wire logic bus_grant_n_i,
  input wire logic nonmaskable_irq_n_i,
  // pipeline side
  input wire logic [EXC_N-1:0] exc_req_i, // raised sources, one per bit
  input wire logic exception_return_instruction_i,
  input wire logic [63:0] pc_i,
  input wire logic [63:0] fault_vaddr_i,
  input wire logic [CFG_W-1:0] boot_mode_bits_i,
  input wire logic cpu_64bit_mode_i,
  // software-written status bits
  input wire logic sw_exl_clear_i, // software write clearing level bit
  input wire logic sw_bev_clear_i, // software clears boot vector select
  input wire logic user_extended_addressing_i,
  input wire logic supervisor_extended_addressing_i,
  input wire logic kernel_extended_addressing_i,
  // results
  output logic exception_level_bit_o,
  output logic error_level_bit_o,
  output logic boot_vector_select_o,
  output logic soft_reset_flag_o,
  output logic tlb_shutdown_flag_o,
  output logic cache_error_hold_flag_o,
  output logic [63:0] error_return_pc_o,
  output logic [VPN2_W-1:0] faulting_page_pair_number_o,
  output logic [VPN2_W-1:0] faulting_page_pair_number_x_o,
  output logic [5:0] random_index_o,
  output logic [5:0] wired_count_o,
  output logic [31:0] frame_filter_reg_o,
  output logic [CFG_W-1:0] config_reg_o,
  output logic [3:0] branch_predict_bits_o,
  output logic [7:0] perf_event_field_o,
  output logic pending_clear_o, // pulse: drop pending cache errors
  output logic pending_all_clear_o, // pulse: drop watches and irqs too
  output logic redirect_o, // pulse: fetch from vector_o
  output logic [63:0] vector_o,
  output logic [4:0] exc_code_o
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  // index of the highest priority raised source; lower index wins
  function automatic logic [4:0] pick_source(input logic [EXC_N-1:0] req);
    logic [4:0] idx;
    idx = 5'h1F;
    for (int i = EXC_N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : pick_source

  // is this source a tlb translation fault
  function automatic logic is_tlb(input logic [4:0] idx);
    return (idx == 5'(EX_IREFILL)) || (idx == 5'(EX_IINVALID)) || (idx == 5'(EX_DREFILL)) ||
           (idx == 5'(EX_DINVALID)) || (idx == 5'(EX_DMOD));
  endfunction : is_tlb

  ////////////////////////////////////////////////////////////////////////
  // reset pin sampling and decode

  logic sysrst_q; // registered asserted-level of the reset pin
  logic grant_q;
  logic nmi_q;
  logic nmi_prev_q;
  cevr_rst_e rst_state_q;
  logic cold_ev; // one-cycle decode results
  logic soft_ev;
  logic nmi_ev;

  // pins taken as synchronous, one register stage
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sysrst_q <= 1'b0;
      grant_q <= 1'b0;
      nmi_q <= 1'b0;
      nmi_prev_q <= 1'b0;
    end else begin
      sysrst_q <= ~system_reset_n_i;
      grant_q <= ~bus_grant_n_i;
      nmi_q <= ~nonmaskable_irq_n_i;
      nmi_prev_q <= nmi_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rst_state_q <= CEVR_RUN;
    end else begin
      case (rst_state_q)
        CEVR_RUN: if (sysrst_q) rst_state_q <= CEVR_DONE;
        CEVR_DONE: if (!sysrst_q) rst_state_q <= CEVR_RUN;
        default: rst_state_q <= CEVR_RUN;
      endcase
    end
  end

  // grant picks cold; no mask term exists
  assign cold_ev = sysrst_q && (rst_state_q == CEVR_RUN) && grant_q;
  assign soft_ev = sysrst_q && (rst_state_q == CEVR_RUN) && !grant_q;
  // falling edge of active low pin
  assign nmi_ev = nmi_q && !nmi_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // priority and vector choice

  logic [EXC_N-1:0] req_all;
  logic [4:0] src;
  logic any_src;
  logic miss_refill;
  logic use_x;
  logic [63:0] vec_d;

  // nmi folds into the priority vector at the top
  always_comb begin
    req_all = exc_req_i;
    req_all[EX_NMI] = nmi_ev;
  end

  assign src = pick_source(req_all);
  assign any_src = |req_all;
  // refill vector only with level bit clear
  assign miss_refill = ((src == 5'(EX_IREFILL)) || (src == 5'(EX_DREFILL))) && !exception_level_bit_o;

  // address space of the missing address
  always_comb begin
    case (fault_vaddr_i[63:62])
      2'b00: use_x = user_extended_addressing_i;
      // region 01 is the extended supervisor space
      2'b01: use_x = supervisor_extended_addressing_i;
      // kernel region; the half gigabyte supervisor segment in it follows the kernel bit
      2'b11: use_x = kernel_extended_addressing_i;
      default: use_x = kernel_extended_addressing_i;
    endcase
  end

  always_comb begin
    if (src == 5'(EX_NMI)) begin
      vec_d = RESET_VEC;
    end else if (src == 5'(EX_CACHE)) begin
      vec_d = boot_vector_select_o ? CACHE_ERR_VEC_BOOT : CACHE_ERR_VEC_NORM;
    end else if (miss_refill) begin
      vec_d = boot_vector_select_o ? (use_x ? XREFILL_VEC_BOOT : REFILL_VEC_BOOT) :
                                     (use_x ? XREFILL_VEC_NORM : REFILL_VEC_NORM);
    end else begin
      vec_d = boot_vector_select_o ? GENERAL_VEC_BOOT : GENERAL_VEC_NORM;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // redirect and code outputs

  // reset events outrank every source; any cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      redirect_o <= 1'b0;
      vector_o <= RESET_VEC;
      exc_code_o <= CEVR_EX_NONE;
    end else if (cold_ev || soft_ev) begin
      redirect_o <= 1'b1;
      vector_o <= (cold_ev && !cpu_64bit_mode_i) ? {32'h0000_0000, RESET_VEC[31:0]} : RESET_VEC;
      exc_code_o <= cold_ev ? CEVR_EX_COLD : CEVR_EX_SOFT;
    end else if (any_src) begin
      redirect_o <= 1'b1;
      vector_o <= vec_d;
      exc_code_o <= CEVR_EX_SRC | src;
    end else begin
      redirect_o <= 1'b0;
      exc_code_o <= CEVR_EX_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status bits

  // level bit: set on any exception other than reset or nmi, wins over clears
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      exception_level_bit_o <= 1'b0;
    end else if (any_src && !cold_ev && !soft_ev && src != 5'(EX_NMI)) begin
      exception_level_bit_o <= 1'b1;
    end else if (exception_return_instruction_i || sw_exl_clear_i) begin
      exception_level_bit_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      error_level_bit_o <= 1'b1;
      boot_vector_select_o <= 1'b1;
      soft_reset_flag_o <= 1'b0;
      tlb_shutdown_flag_o <= 1'b0;
    end else if (cold_ev) begin
      error_level_bit_o <= 1'b1;
      boot_vector_select_o <= 1'b1;
      soft_reset_flag_o <= 1'b0;
      tlb_shutdown_flag_o <= 1'b0;
    end else if (soft_ev || src == 5'(EX_NMI)) begin
      // soft reset and nmi: same writes so software sees no difference
      error_level_bit_o <= 1'b1;
      boot_vector_select_o <= 1'b1;
      soft_reset_flag_o <= 1'b1;
      tlb_shutdown_flag_o <= 1'b0;
    end else if (exception_return_instruction_i && error_level_bit_o) begin
      error_level_bit_o <= 1'b0;
    end else if (sw_bev_clear_i) begin
      boot_vector_select_o <= 1'b0;
    end
  end

  // pc saved on any reset type or nmi
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      error_return_pc_o <= 64'h0000_0000_0000_0000;
    end else if (cold_ev || soft_ev || src == 5'(EX_NMI)) begin
      error_return_pc_o <= pc_i;
    end
  end

  // both page pair fields on every tlb fault
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      faulting_page_pair_number_o <= '0;
      faulting_page_pair_number_x_o <= '0;
    end else if (any_src && !cold_ev && !soft_ev && is_tlb(src)) begin
      faulting_page_pair_number_o <= fault_vaddr_i[VPN2_LSB +: VPN2_W];
      faulting_page_pair_number_x_o <= fault_vaddr_i[VPN2_LSB +: VPN2_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      random_index_o <= RANDOM_UPPER;
      wired_count_o <= 6'h00;
      cache_error_hold_flag_o <= 1'b0;
      frame_filter_reg_o <= 32'h0000_0000;
      branch_predict_bits_o <= 4'h0;
      perf_event_field_o <= 8'h00;
      config_reg_o <= '0;
    end else if (cold_ev) begin
      random_index_o <= RANDOM_UPPER;
      wired_count_o <= 6'h00;
      cache_error_hold_flag_o <= 1'b0;
      frame_filter_reg_o <= 32'h0000_0000;
      branch_predict_bits_o <= 4'h0;
      perf_event_field_o <= 8'h00;
      config_reg_o <= boot_mode_bits_i;
    end else begin
      // random walks down toward the wired count, wrapping at the bound
      random_index_o <= (random_index_o <= wired_count_o) ? RANDOM_UPPER : random_index_o - 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pending_clear_o <= 1'b0;
      pending_all_clear_o <= 1'b0;
    end else begin
      pending_clear_o <= cold_ev || soft_ev || (src == 5'(EX_NMI));
      pending_all_clear_o <= cold_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_cold;
    sysrst_q && grant_q && rst_state_q == CEVR_RUN;
  endsequence

  AST_COLD_VEC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_cold |=> redirect_o && exc_code_o == CEVR_EX_COLD && vector_o[31:0] == RESET_VEC[31:0])
    else $error("cold reset vector wrong");
  AST_COLD_BITS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_cold |=> error_level_bit_o && boot_vector_select_o && !soft_reset_flag_o && !tlb_shutdown_flag_o)
    else $error("cold reset status wrong");
  AST_SOFT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sysrst_q && !grant_q && rst_state_q == CEVR_RUN) |=> soft_reset_flag_o && error_level_bit_o
    && vector_o == RESET_VEC && error_return_pc_o == $past(pc_i))
    else $error("soft reset state wrong");
  AST_ONCE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sysrst_q && rst_state_q == CEVR_RUN) ##1 sysrst_q |=> exc_code_o != CEVR_EX_COLD && exc_code_o != CEVR_EX_SOFT)
    else $error("reset decoded twice");
  AST_EXL_SET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (any_src && !cold_ev && !soft_ev && src != 5'(EX_NMI)) |=> exception_level_bit_o)
    else $error("level bit not set");
  AST_EXCEPTION_RETURN_INSTRUCTION: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (exception_return_instruction_i && !any_src && !cold_ev && !soft_ev) |=> !exception_level_bit_o)
    else $error("level bit not cleared");
  AST_CACHE_UNC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (redirect_o && exc_code_o == (CEVR_EX_SRC | 5'(EX_CACHE))) |-> vector_o[31:29] == 3'b101)
    else $error("cache error vector cached");
  AST_PRIO: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!cold_ev && !soft_ev && !req_all[EX_NMI] && req_all[EX_CACHE] && req_all[EX_INTR])
    |=> exc_code_o == (CEVR_EX_SRC | 5'(EX_CACHE)))
    else $error("priority wrong");
  AST_REFILL_EXL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!cold_ev && !soft_ev && src == 5'(EX_DREFILL) && exception_level_bit_o) |=> vector_o[8:0] == 9'h180)
    else $error("refill with level bit not general");
  AST_VPN: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!cold_ev && !soft_ev && any_src && is_tlb(src)) |=> faulting_page_pair_number_x_o == $past(fault_vaddr_i[43:13]))
    else $error("page pair not loaded");

endmodule : cevr_unit

/* cevr_pkg.sv */
// package for the cpu exception vector and reset unit
// assumes a 64-bit virtual address space and a single core clock
package cevr_pkg;

  // vector addresses
  localparam logic [63:0] RESET_VEC = 64'hFFFF_FFFF_BFC0_0000;
  localparam logic [63:0] REFILL_VEC_NORM = 64'hFFFF_FFFF_8000_0000;
  // 64-bit refill shares the refill entry; the handler splits the two page tables
  localparam logic [63:0] XREFILL_VEC_NORM = 64'hFFFF_FFFF_8000_0000;
  localparam logic [63:0] CACHE_ERR_VEC_NORM = 64'hFFFF_FFFF_A000_0100;
  localparam logic [63:0] GENERAL_VEC_NORM = 64'hFFFF_FFFF_8000_0180;
  localparam logic [63:0] REFILL_VEC_BOOT = 64'hFFFF_FFFF_BFC0_0200;
  localparam logic [63:0] XREFILL_VEC_BOOT = 64'hFFFF_FFFF_BFC0_0200;
  localparam logic [63:0] CACHE_ERR_VEC_BOOT = 64'hFFFF_FFFF_BFC0_0300;
  localparam logic [63:0] GENERAL_VEC_BOOT = 64'hFFFF_FFFF_BFC0_0380;

  // random index upper bound and field widths
  localparam logic [5:0] RANDOM_UPPER = 6'h3F;
  localparam int CFG_W = 16;
  localparam int VPN2_W = 31;
  localparam int VPN2_LSB = 13;

  // exception source bit positions, highest priority first (index 0)
  localparam int EXC_N = 16;
  localparam int EX_NMI = 0;
  localparam int EX_CACHE = 1;
  localparam int EX_IADDR = 2;
  localparam int EX_IREFILL = 3;
  localparam int EX_IINVALID = 4;
  localparam int EX_IBUS = 5;
  localparam int EX_INSTR = 6;
  localparam int EX_DADDR = 7;
  localparam int EX_DREFILL = 8;
  localparam int EX_DINVALID = 9;
  localparam int EX_DMOD = 10;
  localparam int EX_WATCH = 11;
  localparam int EX_DBUS = 12;
  localparam int EX_INTR = 13;

  // reported exception codes
  typedef enum logic [4:0] {
    CEVR_EX_NONE = 5'h00,
    CEVR_EX_COLD = 5'h01,
    CEVR_EX_SOFT = 5'h02,
    CEVR_EX_SRC = 5'h10
  } cevr_exc_e;

  // reset sequencing
  typedef enum logic [1:0] {
    CEVR_RUN = 2'b00,
    CEVR_IN_RESET = 2'b01,
    CEVR_DONE = 2'b10
  } cevr_rst_e;

endpackage : cevr_pkg

/* cevr_sys_model.sv */
// partner model: external system logic on the reset, grant and nmi pins
// assumes the bench calls its tasks from one process at clk_i edge plus 1 ns
`timescale 1ns/10ps

module cevr_sys_model (
  input wire logic clk_i,
  output logic system_reset_n_o,
  output logic bus_grant_n_o,
  output logic nonmaskable_irq_n_o
);

  // all pins idle negated from time zero, as pulled-up system lines would be
  initial begin
    system_reset_n_o = 1'b1;
    bus_grant_n_o = 1'b1;
    nonmaskable_irq_n_o = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // grant decides reset type
  // grant goes low with reset for cold, stays high for soft
  task automatic drive_reset(input logic cold);
    @(posedge clk_i);
    #1;
    bus_grant_n_o = ~cold;
    system_reset_n_o = 1'b0;
  endtask : drive_reset

  // cold sequence after dump
  // release both pins together; the bench follows a soft dump with a cold one
  task automatic release_reset();
    @(posedge clk_i);
    #1;
    system_reset_n_o = 1'b1;
    bus_grant_n_o = 1'b1;
  endtask : release_reset

  // level on the active low nmi pin, held until the bench lets go
  task automatic set_nmi(input logic asserted);
    @(posedge clk_i);
    #1;
    nonmaskable_irq_n_o = ~asserted;
  endtask : set_nmi

endmodule : cevr_sys_model

/* tb_top.sv */
// testbench for the exception vector and reset unit
// assumes cevr_pkg compiled first; the pin partner lives in cevr_sys_model
`timescale 1ns/10ps

module tb_top;
  import cevr_pkg::*;

  // design inputs, named as the ports so instances connect by name
  logic clk_i, reset_n_i, system_reset_n_i, bus_grant_n_i, nonmaskable_irq_n_i;
  logic [EXC_N-1:0] exc_req_i;
  logic exception_return_instruction_i, cpu_64bit_mode_i, sw_exl_clear_i, sw_bev_clear_i;
  logic [63:0] pc_i, fault_vaddr_i;
  logic [CFG_W-1:0] boot_mode_bits_i;
  logic user_extended_addressing_i, supervisor_extended_addressing_i, kernel_extended_addressing_i;
  // design outputs
  logic exception_level_bit_o, error_level_bit_o, boot_vector_select_o, soft_reset_flag_o;
  logic tlb_shutdown_flag_o, cache_error_hold_flag_o, pending_clear_o, pending_all_clear_o, redirect_o;
  logic [63:0] error_return_pc_o, vector_o;
  logic [VPN2_W-1:0] faulting_page_pair_number_o, faulting_page_pair_number_x_o;
  logic [5:0] random_index_o, wired_count_o;
  logic [31:0] frame_filter_reg_o;
  logic [CFG_W-1:0] config_reg_o;
  logic [3:0] branch_predict_bits_o;
  logic [7:0] perf_event_field_o;
  logic [4:0] exc_code_o;
  int num_errors = 0;
  int samples_checked = 0;
  // a user address and one in the supervisor mapped half gigabyte
  localparam logic [63:0] UA = 64'h0000_0000_0040_2000;
  localparam logic [63:0] SA = 64'hFFFF_FFFF_C000_6000;

  cevr_unit cevr_unit_inst (.clk_i, .reset_n_i, .system_reset_n_i, .bus_grant_n_i, .nonmaskable_irq_n_i,
    .exc_req_i, .exception_return_instruction_i, .pc_i, .fault_vaddr_i, .boot_mode_bits_i,
    .cpu_64bit_mode_i, .sw_exl_clear_i, .sw_bev_clear_i, .user_extended_addressing_i,
    .supervisor_extended_addressing_i, .kernel_extended_addressing_i, .exception_level_bit_o,
    .error_level_bit_o, .boot_vector_select_o, .soft_reset_flag_o, .tlb_shutdown_flag_o,
    .cache_error_hold_flag_o, .error_return_pc_o, .faulting_page_pair_number_o,
    .faulting_page_pair_number_x_o, .random_index_o, .wired_count_o, .frame_filter_reg_o, .config_reg_o,
    .branch_predict_bits_o, .perf_event_field_o, .pending_clear_o, .pending_all_clear_o, .redirect_o,
    .vector_o, .exc_code_o);

  cevr_sys_model cevr_sys_model_inst (.clk_i, .system_reset_n_o(system_reset_n_i),
    .bus_grant_n_o(bus_grant_n_i), .nonmaskable_irq_n_o(nonmaskable_irq_n_i));

  //////////////////////////////////////////////////////////////////////////
  // 100 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // compare and count; four-state so an unknown never matches
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // the single place where the run ends
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // bounded wait for the redirect pulse after a pin change
  task automatic wait_redirect();
    int n;
    n = 0;
    while (redirect_o !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (redirect_o !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t no redirect seen", $time);
      report_and_stop();
    end
  endtask : wait_redirect

  // one-cycle return pulse; level bit must drop
  task automatic exception_return_instruction();
    exception_return_instruction_i = 1'b1;
    @(posedge clk_i);
    #1;
    exception_return_instruction_i = 1'b0;
    chk(exception_level_bit_o, 1'b0);
  endtask : exception_return_instruction

  // raise a set of sources for one cycle and check the answer on the next
  task automatic tv(input logic clr, input logic [EXC_N-1:0] req, input logic [63:0] va,
                    input logic [63:0] v, input logic [4:0] code);
    if (clr) begin
      exception_return_instruction();
    end
    exc_req_i = req;
    fault_vaddr_i = va;
    @(posedge clk_i);
    #1;
    exc_req_i = '0;
    chk(redirect_o, 1'b1);
    chk(vector_o, v);
    chk(exc_code_o, code);
    chk(exception_level_bit_o, 1'b1);
  endtask : tv

  // cold reset through the pins, then held to see it decoded only once
  task automatic cold_check(input logic m64, input logic [63:0] v);
    logic [3:0] n;
    cpu_64bit_mode_i = m64;
    cevr_sys_model_inst.drive_reset(1'b1);
    wait_redirect();
    chk(exc_code_o, CEVR_EX_COLD);
    chk(vector_o, v);
    chk(error_return_pc_o, pc_i);
    chk(config_reg_o, boot_mode_bits_i);
    chk({soft_reset_flag_o, tlb_shutdown_flag_o, error_level_bit_o, boot_vector_select_o}, 4'h3);
    chk({random_index_o, wired_count_o, cache_error_hold_flag_o}, {RANDOM_UPPER, 7'h00});
    chk({frame_filter_reg_o, branch_predict_bits_o, perf_event_field_o}, 64'h0000);
    chk(pending_all_clear_o, 1'b1);
    n = 4'h0;
    repeat (6) begin
      @(posedge clk_i);
      #1;
      n = n + 4'(redirect_o);
    end
    chk(n, 4'h0);
    cevr_sys_model_inst.release_reset();
    repeat (3) @(posedge clk_i);
    #1;
    $display("test cold reset done");
  endtask : cold_check

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_n_i = 1'b0;
    exc_req_i = '0;
    {exception_return_instruction_i, sw_exl_clear_i, sw_bev_clear_i, cpu_64bit_mode_i} = 4'h0;
    {user_extended_addressing_i, supervisor_extended_addressing_i, kernel_extended_addressing_i} = 3'h0;
    pc_i = 64'hFFFF_FFFF_8000_1234;
    fault_vaddr_i = 64'h0000;
    boot_mode_bits_i = 16'hA5C3;
    repeat (10) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    chk({error_level_bit_o, boot_vector_select_o, redirect_o}, 3'h6);
    chk(random_index_o, RANDOM_UPPER);
    cold_check(1'b1, RESET_VEC);
    cold_check(1'b0, 64'h0000_0000_BFC0_0000);
    // boot vectors while the boot bit is still set
    tv(1'b1, 16'h0008, UA, REFILL_VEC_BOOT, 5'h13);
    tv(1'b1, 16'h0002, UA, CACHE_ERR_VEC_BOOT, 5'h11);
    tv(1'b1, 16'h0040, UA, GENERAL_VEC_BOOT, 5'h16);
    user_extended_addressing_i = 1'b1;
    tv(1'b1, 16'h0100, UA, XREFILL_VEC_BOOT, 5'h18);
    $display("test boot vectors done");
    sw_bev_clear_i = 1'b1;
    @(posedge clk_i);
    #1;
    sw_bev_clear_i = 1'b0;
    chk(boot_vector_select_o, 1'b0);
    user_extended_addressing_i = 1'b0;
    tv(1'b1, 16'h0100, UA, REFILL_VEC_NORM, 5'h18);
    chk({faulting_page_pair_number_o, faulting_page_pair_number_x_o}, {2{UA[43:13]}});
    tv(1'b0, 16'h0100, UA, GENERAL_VEC_NORM, 5'h18);
    tv(1'b1, 16'h0002, UA, CACHE_ERR_VEC_NORM, 5'h11);
    tv(1'b1, 16'h0400, UA, GENERAL_VEC_NORM, 5'h1A);
    tv(1'b1, 16'h0200, SA, GENERAL_VEC_NORM, 5'h19);
    chk({faulting_page_pair_number_o, faulting_page_pair_number_x_o}, {2{SA[43:13]}});
    supervisor_extended_addressing_i = 1'b1;
    tv(1'b1, 16'h0100, SA, REFILL_VEC_NORM, 5'h18);
    supervisor_extended_addressing_i = 1'b0;
    kernel_extended_addressing_i = 1'b1;
    tv(1'b1, 16'h0100, SA, XREFILL_VEC_NORM, 5'h18);
    $display("test normal vectors done");
    tv(1'b1, 16'h2108, UA, REFILL_VEC_NORM, 5'h13);
    tv(1'b1, 16'h2046, UA, CACHE_ERR_VEC_NORM, 5'h11);
    tv(1'b1, 16'h3000, UA, GENERAL_VEC_NORM, 5'h1C);
    // handler clears the level bit by a software write
    sw_exl_clear_i = 1'b1;
    @(posedge clk_i);
    #1;
    sw_exl_clear_i = 1'b0;
    chk(exception_level_bit_o, 1'b0);
    $display("test priority done");
    // nmi, then a soft reset with a new pc that must load and new boot bits that must not
    cevr_sys_model_inst.set_nmi(1'b1);
    wait_redirect();
    chk(vector_o, RESET_VEC);
    chk({soft_reset_flag_o, error_level_bit_o, boot_vector_select_o, tlb_shutdown_flag_o}, 4'hE);
    chk({error_return_pc_o, pending_clear_o}, {pc_i, 1'b1});
    cevr_sys_model_inst.set_nmi(1'b0);
    exception_return_instruction();
    pc_i = 64'hFFFF_FFFF_8000_5678;
    boot_mode_bits_i = 16'h3C5A;
    cevr_sys_model_inst.drive_reset(1'b0);
    wait_redirect();
    chk(exc_code_o, CEVR_EX_SOFT);
    chk(vector_o, RESET_VEC);
    chk({soft_reset_flag_o, error_level_bit_o, boot_vector_select_o, tlb_shutdown_flag_o}, 4'hE);
    chk(error_return_pc_o, pc_i);
    chk(config_reg_o, 16'hA5C3);
    chk({pending_clear_o, pending_all_clear_o}, 2'h2);
    cevr_sys_model_inst.release_reset();
    $display("test nmi and soft reset done");
    cold_check(1'b1, RESET_VEC);
    report_and_stop();
  end

endmodule : tb_top
